// ==== hw/speech_cmd_pkg.sv ====
// Shared constants for the speech command link: opcodes, field positions, offsets
package speech_cmd_pkg;
   localparam int          NUM_CH          = 4;
   localparam int          PHRASE_W        = 12;
   localparam int          ATT_W           = 4;
   // ------------------------------------------------------------
   // First-byte opcodes
   // ------------------------------------------------------------
   localparam logic [7:0]  OP_PHRASE_SET   = 8'hC4;
   localparam logic [7:0]  OP_PHRASE_PLAY  = 8'hC8;
   localparam logic [6:0]  OP_MONITOR_HI   = 7'h68;
   localparam logic [7:0]  OP_ERR_CLEAR    = 8'hFF;
   localparam logic [5:0]  OP_ATTEN_HI     = 6'h3C;
   localparam logic [7:0]  OP_SAI_CHANNEL  = 8'hE1;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int          CH_CODE_LSB     = 4;
   localparam int          PHRASE_HI_MSB   = 3;
   localparam int          BANK_SEL_BIT    = 0;
   localparam int          WDT_EN_BIT      = 5;
   localparam int          RST_EN_BIT      = 6;
   localparam logic [7:0]  BANK1_MASK      = 8'hF1;
   localparam int          ATT_RIGHT_LSB   = 4;
   localparam int          LEFT_SEL_LSB    = 5;
   localparam int          LEFT_EN_BIT     = 4;
   localparam int          RIGHT_SEL_LSB   = 1;
   localparam int          RIGHT_EN_BIT    = 0;
   // ------------------------------------------------------------
   // Reset values and attenuation mute code
   // ------------------------------------------------------------
   localparam logic [7:0]  MONITOR_RST     = 8'h00;
   localparam logic [3:0]  ATT_RST         = 4'h0;
   localparam logic [3:0]  ATT_MUTE        = 4'hF;
   // ------------------------------------------------------------
   // Host APB register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] REG_TX_BYTE     = 12'h000;
   localparam logic [11:0] REG_STATUS      = 12'h004;
endpackage

// ==== hw/speech_link_if.sv ====
// Byte-wide command link between host controller and speech device
`timescale 1ns/100ps
interface speech_link_if;
   logic       cmd_valid;
   logic [7:0] cmd_byte;
   logic       cmd_ready;
   logic [3:0] accept_flag;
   logic [3:0] playing_n;
   modport dev  (input cmd_valid, input cmd_byte, output cmd_ready,
                 output accept_flag, output playing_n);
   modport host (output cmd_valid, output cmd_byte, input cmd_ready,
                 input accept_flag, input playing_n);
endinterface

// ==== hw/speech_cmd_dev.sv ====
// Device end: command byte decoder, monitor enables, error flags, audio routing
//
// Behaviour
// - three-byte phrase set, channel and 12-bit phrase
// - phrase commands need addressed channel accept flag
// - phrase set stores only, never starts playback
// - play command stores phrase and starts playback once silence ends
// - channel code 00..11 selects channel 0..3
// - monitor command bit0 selects enable bank
// - monitor enables reset to zero, one starts
// - banks held independently of each other
// - bank0 bit order clock-stop down to command-error
// - bank1 mix, input, frame, bit clocks, waveform
// - watchdog plus reset counter keeps reset counter
// - all-ones byte clears every flag, ungated
// - persisting condition keeps its flag set
// - attenuation channel in byte1, right/left nibbles
// - attenuation resets to 0 dB, 1111 mutes
// - channel command fields and enables reset stopped
// - refuse enable while chosen channel plays memory
// - host clears both enables before swapping side
// - same channel both sides drives left only
// - host orders interface, clocks, silence, channel command
// - playback start deferred until silence ends
// - fast frame clock returns routing to reset
// - bad command sets command error flag
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps
module speech_cmd_dev (
   input  wire logic                                  pclk,
   input  wire logic                                  presetn,
   speech_link_if.dev                                 link,
   input  wire logic [3:0]                            accept_flag_in,
   input  wire logic [3:0]                            playing_n_in,
   input  wire logic                                  silence_active,
   input  wire logic                                  frame_clock_fast,
   input  wire logic [7:1]                            err_cond_b0,
   input  wire logic [7:0]                            err_cond_b1,
   output logic [3:0][speech_cmd_pkg::PHRASE_W-1:0]   phrase,
   output logic [3:0]                                 play_start,
   output logic [7:0]                                 monitor_en_b0,
   output logic [7:0]                                 monitor_en_b1,
   output logic [7:0]                                 err_flag_b0,
   output logic [7:0]                                 err_flag_b1,
   output logic [3:0][speech_cmd_pkg::ATT_W-1:0]      atten_right,
   output logic [3:0][speech_cmd_pkg::ATT_W-1:0]      atten_left,
   output logic [3:0][speech_cmd_pkg::ATT_W-1:0]      gain_right_code,
   output logic [1:0]                                 left_channel_select,
   output logic                                       left_side_enable,
   output logic [1:0]                                 right_channel_select,
   output logic                                       right_side_enable,
   output logic                                       right_side_active
);
   typedef enum logic [1:0] {ST_OP, ST_B2, ST_B3} parse_state_t;

   parse_state_t state_q;
   logic [7:0]   op_q;
   logic [7:0]   b2_q;
   logic [7:0]   b;
   logic         take;
   logic         op_known;
   logic         op_multi;
   logic         op_three;
   logic         bad_ev;
   logic         clr_ev;
   logic         two_ev;
   logic         three_ev;
   logic [1:0]   ph_ch;
   logic         mon_ev;
   logic         att_ev;
   logic         sai_ev;
   logic         sai_refuse;
   logic [7:0]   mon_wr;

   assign link.cmd_ready   = 1'b1;
   assign link.accept_flag = accept_flag_in;
   assign link.playing_n   = playing_n_in;
   assign take             = link.cmd_valid;
   assign b                = link.cmd_byte;

   // ------------------------------------------------------------
   // Opcode classification
   // ------------------------------------------------------------
   always_comb begin
      op_three = (b == speech_cmd_pkg::OP_PHRASE_SET) || (b == speech_cmd_pkg::OP_PHRASE_PLAY);
      op_multi = op_three || (b[7:1] == speech_cmd_pkg::OP_MONITOR_HI)
                 || (b[7:2] == speech_cmd_pkg::OP_ATTEN_HI)
                 || (b == speech_cmd_pkg::OP_SAI_CHANNEL);
      op_known = op_multi || (b == speech_cmd_pkg::OP_ERR_CLEAR);
   end

   assign bad_ev   = take && (state_q == ST_OP) && !op_known;
   assign clr_ev   = take && (state_q == ST_OP) && (b == speech_cmd_pkg::OP_ERR_CLEAR);
   assign three_ev = take && (state_q == ST_B3);
   assign two_ev   = take && (state_q == ST_B2) && (op_q != speech_cmd_pkg::OP_PHRASE_SET)
                     && (op_q != speech_cmd_pkg::OP_PHRASE_PLAY);
   assign ph_ch    = b2_q[speech_cmd_pkg::CH_CODE_LSB +: 2];
   assign mon_ev   = two_ev && (op_q[7:1] == speech_cmd_pkg::OP_MONITOR_HI);
   assign att_ev   = two_ev && (op_q[7:2] == speech_cmd_pkg::OP_ATTEN_HI);
   assign sai_ev   = two_ev && (op_q == speech_cmd_pkg::OP_SAI_CHANNEL);

   // ------------------------------------------------------------
   // Byte sequencer
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_OP;
         op_q    <= 8'h00;
         b2_q    <= 8'h00;
      end else if (take) begin
         case (state_q)
            ST_OP: begin
               op_q <= b;
               if (op_multi) begin
                  state_q <= ST_B2;
               end
            end
            ST_B2: begin
               b2_q <= b;
               if ((op_q == speech_cmd_pkg::OP_PHRASE_SET)
                   || (op_q == speech_cmd_pkg::OP_PHRASE_PLAY)) begin
                  state_q <= ST_B3;
               end else begin
                  state_q <= ST_OP;
               end
            end
            ST_B3: state_q <= ST_OP;
            default: state_q <= ST_OP;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Per-channel phrase, start and attenuation
   // ------------------------------------------------------------
   for (genvar i = 0; i < speech_cmd_pkg::NUM_CH; i++) begin : g_ch
      logic hit;
      logic pend_q;
      // Refused commands fall through without touching state
      assign hit = three_ev && (ph_ch == 2'(i)) && accept_flag_in[i];

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            phrase[i] <= '0;
         end else if (hit) begin
            phrase[i] <= {b2_q[speech_cmd_pkg::PHRASE_HI_MSB:0], b};
         end
      end

      // Play request waits out any silence period; set wins over issue
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pend_q        <= 1'b0;
            play_start[i] <= 1'b0;
         end else begin
            play_start[i] <= pend_q && !silence_active;
            if (hit && (op_q == speech_cmd_pkg::OP_PHRASE_PLAY)) begin
               pend_q <= 1'b1;
            end else if (!silence_active) begin
               pend_q <= 1'b0;
            end
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            atten_right[i] <= speech_cmd_pkg::ATT_RST;
            atten_left[i]  <= speech_cmd_pkg::ATT_RST;
         end else if (att_ev && (op_q[1:0] == 2'(i))) begin
            atten_right[i] <= b[speech_cmd_pkg::ATT_RIGHT_LSB +: speech_cmd_pkg::ATT_W];
            atten_left[i]  <= b[speech_cmd_pkg::ATT_W-1:0];
         end
      end

      // Mute code passes through; downstream gain treats it as off
      assign gain_right_code[i] = (atten_right[i] == speech_cmd_pkg::ATT_MUTE)
                                  ? speech_cmd_pkg::ATT_MUTE : atten_right[i];
   end

   // ------------------------------------------------------------
   // Monitor enable banks
   // ------------------------------------------------------------
   always_comb begin
      mon_wr = b;
      if (b[speech_cmd_pkg::RST_EN_BIT] && b[speech_cmd_pkg::WDT_EN_BIT]) begin
         mon_wr[speech_cmd_pkg::WDT_EN_BIT] = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         monitor_en_b0 <= speech_cmd_pkg::MONITOR_RST;
         monitor_en_b1 <= speech_cmd_pkg::MONITOR_RST;
      end else if (mon_ev) begin
         if (op_q[speech_cmd_pkg::BANK_SEL_BIT]) begin
            monitor_en_b1 <= b & speech_cmd_pkg::BANK1_MASK;
         end else begin
            monitor_en_b0 <= mon_wr;
         end
      end
   end

   // ------------------------------------------------------------
   // Sticky error flags: a live condition beats the clear
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_flag_b0 <= 8'h00;
         err_flag_b1 <= 8'h00;
      end else begin
         err_flag_b0 <= (clr_ev ? 8'h00 : err_flag_b0)
                        | ({err_cond_b0, bad_ev} & monitor_en_b0);
         err_flag_b1 <= (clr_ev ? 8'h00 : err_flag_b1)
                        | (err_cond_b1 & monitor_en_b1 & speech_cmd_pkg::BANK1_MASK);
      end
   end

   // ------------------------------------------------------------
   // Serial audio side routing
   // ------------------------------------------------------------
   assign sai_refuse =
      (b[speech_cmd_pkg::LEFT_EN_BIT]  && !playing_n_in[b[speech_cmd_pkg::LEFT_SEL_LSB +: 2]])
   || (b[speech_cmd_pkg::RIGHT_EN_BIT] && !playing_n_in[b[speech_cmd_pkg::RIGHT_SEL_LSB +: 2]]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_channel_select  <= 2'h0;
         left_side_enable     <= 1'b0;
         right_channel_select <= 2'h0;
         right_side_enable    <= 1'b0;
      end else if (frame_clock_fast) begin
         left_channel_select  <= 2'h0;
         left_side_enable     <= 1'b0;
         right_channel_select <= 2'h0;
         right_side_enable    <= 1'b0;
      end else if (sai_ev && !sai_refuse) begin
         left_channel_select  <= b[speech_cmd_pkg::LEFT_SEL_LSB +: 2];
         left_side_enable     <= b[speech_cmd_pkg::LEFT_EN_BIT];
         right_channel_select <= b[speech_cmd_pkg::RIGHT_SEL_LSB +: 2];
         right_side_enable    <= b[speech_cmd_pkg::RIGHT_EN_BIT];
      end
   end

   assign right_side_active = right_side_enable
      && !(left_side_enable && (left_channel_select == right_channel_select));
endmodule // speech_cmd_dev

// ==== hw/speech_cmd_host.sv ====
// Host end: APB slave that pushes command bytes onto the link and reports link status
`timescale 1ns/100ps
module speech_cmd_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   speech_link_if.host      link
);
   logic       valid_q;
   logic [7:0] byte_q;
   logic       hit_tx;
   logic       hit_st;
   logic       access;

   assign hit_tx = (paddr == speech_cmd_pkg::REG_TX_BYTE);
   assign hit_st = (paddr == speech_cmd_pkg::REG_STATUS);
   assign access = psel && penable;
   // Write to the byte register stalls while the previous byte is unsent
   assign pready  = !(hit_tx && pwrite && valid_q);
   assign pslverr = access && !hit_tx && !hit_st;

   assign link.cmd_valid = valid_q;
   assign link.cmd_byte  = byte_q;

   // ------------------------------------------------------------
   // Outgoing byte
   // ------------------------------------------------------------
   // Host software must itself honour accept flags and side ordering
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_q <= 1'b0;
         byte_q  <= 8'h00;
      end else if (access && pready && pwrite && hit_tx) begin
         valid_q <= 1'b1;
         byte_q  <= pwdata[7:0];
      end else if (link.cmd_ready) begin
         valid_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Read data, loaded in the setup cycle
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         if (hit_tx) begin
            prdata <= {24'h00_0000, byte_q};
         end else if (hit_st) begin
            prdata <= {20'h0_0000, link.playing_n, link.accept_flag, 3'h0, valid_q};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end
endmodule // speech_cmd_host

// ==== tb/speech_cmd_phrase_fault_sai_asserts.sv ====
// Checker on the command link and the device outputs it controls
`timescale 1ns/100ps
module speech_cmd_phrase_fault_sai_asserts (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       cmd_valid,
   input wire logic       cmd_ready,
   input wire logic [3:0] playing_n,
   input wire logic [3:0] play_start,
   input wire logic       silence_active,
   input wire logic       frame_clock_fast,
   input wire logic [7:0] monitor_en_b0,
   input wire logic [7:0] monitor_en_b1,
   input wire logic [1:0] left_channel_select,
   input wire logic       left_side_enable,
   input wire logic [1:0] right_channel_select,
   input wire logic       right_side_enable,
   input wire logic       right_side_active
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Busy levels as the device saw them when it took the routing byte
   logic [3:0] playing_n_q;
   always_ff @(posedge pclk) begin
      playing_n_q <= playing_n;
   end
   // ------------------------------------------------------------
   // Link framing
   // ------------------------------------------------------------
   a_ready_always_high: assert property (cmd_ready)
      else $error("link ready dropped");
   a_valid_single_beat: assert property (cmd_valid |=> !cmd_valid)
      else $error("byte offered twice");
   a_reset_quiet_link: assert property ($rose(presetn) |-> !cmd_valid && play_start == 4'h0)
      else $error("activity right after reset");
   // ------------------------------------------------------------
   // Monitor enables and playback
   // ------------------------------------------------------------
   a_wdt_rst_excl: assert property (!(monitor_en_b0[5] && monitor_en_b0[6]))
      else $error("watchdog and reset counter both on");
   a_bank1_gap_zero: assert property (monitor_en_b1[3:1] == 3'h0)
      else $error("bank1 reserved bits set");
   a_start_after_silence: assert property (play_start != 4'h0 |-> !$past(silence_active))
      else $error("playback started inside silence");
   a_start_one_pulse: assert property (play_start != 4'h0 |=> play_start == 4'h0)
      else $error("start pulse too long");
   // ------------------------------------------------------------
   // Audio routing
   // ------------------------------------------------------------
   a_left_not_busy: assert property ($rose(left_side_enable)
      |-> playing_n_q[left_channel_select])
      else $error("left enabled on busy channel");
   a_right_not_busy: assert property ($rose(right_side_enable)
      |-> playing_n_q[right_channel_select])
      else $error("right enabled on busy channel");
   a_same_ch_left: assert property (left_side_enable && right_side_enable
      && left_channel_select == right_channel_select |-> !right_side_active)
      else $error("right side active on shared channel");
   a_right_needs_en: assert property (right_side_active |-> right_side_enable)
      else $error("right side active while stopped");
   a_fast_frame_init: assert property (frame_clock_fast |=> !left_side_enable
      && !right_side_enable && left_channel_select == 2'h0
      && right_channel_select == 2'h0)
      else $error("routing kept with fast frame clock");
   c_play_start: cover property (play_start != 4'h0);
   c_right_active: cover property ($rose(right_side_active));
   c_fast_while_on: cover property (frame_clock_fast && left_side_enable);
endmodule // speech_cmd_phrase_fault_sai_asserts

// ==== tb/tb_speech_cmd_phrase_fault_sai.sv ====
// Bench joining host APB end and device end across the command link
`timescale 1ns/100ps
module tb_speech_cmd_phrase_fault_sai;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, rerr, silence_active = 1'b0, frame_clock_fast = 1'b0;
   logic [3:0] accept_flag_in = 4'hF, playing_n_in = 4'hF, play_start, ps_seen = 4'h0;
   logic [7:1] err_cond_b0 = 7'h00;
   logic [7:0] err_cond_b1 = 8'h00, monitor_en_b0, monitor_en_b1, err_flag_b0, err_flag_b1, b;
   logic [3:0][speech_cmd_pkg::PHRASE_W-1:0] phrase;
   logic [3:0][speech_cmd_pkg::ATT_W-1:0] atten_right, atten_left, gain_right_code;
   logic [1:0] left_channel_select, right_channel_select;
   logic left_side_enable, right_side_enable, right_side_active;
   logic [11:0] v;
   // Left-only is always cleared before right-only is asked for
   logic [7:0] sai_seq [8] = '{8'h53, 8'h73, 8'h33, 8'h11, 8'h10, 8'h00, 8'h05, 8'h00};
   int err_count = 0, checks = 0, cycles = 0;

   speech_link_if speech_link_if_i ();
   speech_cmd_dev speech_cmd_dev_i (.pclk(pclk), .presetn(presetn), .link(speech_link_if_i),
      .accept_flag_in(accept_flag_in), .playing_n_in(playing_n_in),
      .silence_active(silence_active), .frame_clock_fast(frame_clock_fast),
      .err_cond_b0(err_cond_b0), .err_cond_b1(err_cond_b1), .phrase(phrase),
      .play_start(play_start), .monitor_en_b0(monitor_en_b0), .monitor_en_b1(monitor_en_b1),
      .err_flag_b0(err_flag_b0), .err_flag_b1(err_flag_b1), .atten_right(atten_right),
      .atten_left(atten_left), .gain_right_code(gain_right_code),
      .left_channel_select(left_channel_select), .left_side_enable(left_side_enable),
      .right_channel_select(right_channel_select), .right_side_enable(right_side_enable),
      .right_side_active(right_side_active));
   speech_cmd_host speech_cmd_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(speech_link_if_i));
   speech_cmd_phrase_fault_sai_asserts speech_cmd_phrase_fault_sai_asserts_i (.pclk(pclk),
      .presetn(presetn), .cmd_valid(speech_link_if_i.cmd_valid),
      .cmd_ready(speech_link_if_i.cmd_ready), .playing_n(speech_link_if_i.playing_n),
      .play_start(play_start), .silence_active(silence_active),
      .frame_clock_fast(frame_clock_fast), .monitor_en_b0(monitor_en_b0),
      .monitor_en_b1(monitor_en_b1), .left_channel_select(left_channel_select),
      .left_side_enable(left_side_enable), .right_channel_select(right_channel_select),
      .right_side_enable(right_side_enable), .right_side_active(right_side_active));

   initial begin
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      ps_seen <= ps_seen | play_start;
      cycles  <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   // ------------------------------------------------------------
   // Tasks and expectations
   // ------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic send(input logic [7:0] x);
      apb(1'b1, speech_cmd_pkg::REG_TX_BYTE, {24'h000000, x});
   endtask
   task automatic settle();
      repeat (3) @(posedge pclk);
      #1;
   endtask
   task automatic cmd3(input logic [7:0] op, input logic [1:0] ch, input logic [11:0] ph);
      send(op);
      send({2'b00, ch, ph[11:8]});
      send(ph[7:0]);
      settle();
   endtask
   function automatic logic [7:0] exp_b0(input logic [7:0] x);
      return x[6] ? (x & 8'hDF) : x;
   endfunction
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(29560));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      chk(monitor_en_b0 | monitor_en_b1, 0, "monitor reset");
      chk(atten_left[2] | atten_right[1], 0, "attenuation reset");
      chk({left_side_enable, right_side_enable}, 0, "routing reset");
      for (int c = 0; c < 4; c++) begin
         v = (c == 3) ? 12'hFFF : 12'($urandom);
         ps_seen = 4'h0;
         cmd3(speech_cmd_pkg::OP_PHRASE_SET, c[1:0], v);
         chk(phrase[c], v, "phrase stored");
         chk(ps_seen, 0, "set started playback");
      end
      for (int s = 0; s < 2; s++) begin
         v = 12'($urandom);
         ps_seen = 4'h0;
         @(posedge pclk);
         silence_active <= s[0];
         cmd3(speech_cmd_pkg::OP_PHRASE_PLAY, 2'(s + 1), v);
         chk(phrase[s + 1], v, "play phrase");
         chk(ps_seen, s ? 4'h0 : 4'h2, "play start");
      end
      @(posedge pclk);
      silence_active <= 1'b0;
      settle();
      chk(ps_seen, 4'h4, "deferred start");
      @(posedge pclk);
      accept_flag_in <= 4'h7;
      cmd3(speech_cmd_pkg::OP_PHRASE_SET, 2'd3, 12'h5A5);
      chk(phrase[3], 12'hFFF, "gated phrase");
      apb(1'b0, speech_cmd_pkg::REG_STATUS, 32'h0);
      chk(rd[7:4], 4'h7, "status accept");
      apb(1'b0, 12'h008, 32'h0);
      chk(rerr, 1'b1, "unmapped error");
      chk(rd, 32'h0, "unmapped read");
      for (int i = 0; i < 6; i++) begin
         b = (i == 0) ? 8'h60 : 8'($urandom);
         send({speech_cmd_pkg::OP_MONITOR_HI, 1'b0});
         send(b);
         settle();
         chk(monitor_en_b0, exp_b0(b), "bank0 enables");
         v = 12'($urandom);
         send({speech_cmd_pkg::OP_MONITOR_HI, 1'b1});
         send(v[7:0]);
         settle();
         chk(monitor_en_b1, v[7:0] & 8'hF1, "bank1 enables");
         chk(monitor_en_b0, exp_b0(b), "bank0 kept");
      end
      send({speech_cmd_pkg::OP_MONITOR_HI, 1'b0});
      send(8'hFF);
      send({speech_cmd_pkg::OP_MONITOR_HI, 1'b1});
      send(8'hFF);
      @(posedge pclk);
      err_cond_b0[4] <= 1'b1;
      err_cond_b1[7] <= 1'b1;
      @(posedge pclk);
      err_cond_b0[4] <= 1'b0;
      err_cond_b1[7] <= 1'b0;
      err_cond_b0[3] <= 1'b1;
      accept_flag_in <= 4'h0;
      send(8'hA5);
      settle();
      chk(err_flag_b0, 8'h19, "flags raised");
      chk(err_flag_b1, 8'h80, "bank1 flag");
      send(speech_cmd_pkg::OP_ERR_CLEAR);
      settle();
      chk(err_flag_b0, 8'h08, "persisting flag");
      chk(err_flag_b1, 8'h00, "flags cleared");
      for (int c = 0; c < 4; c++) begin
         b = (c == 0) ? 8'hF0 : 8'($urandom);
         send({speech_cmd_pkg::OP_ATTEN_HI, c[1:0]});
         send(b);
         settle();
         chk(atten_right[c], b[7:4], "right attenuation");
         chk(atten_left[c], b[3:0], "left attenuation");
         chk(gain_right_code[c], b[7:4], "gain copy");
      end
      for (int i = 0; i < 8; i++) begin
         b = sai_seq[i] | ((i == 3) ? (8'($urandom) & 8'h66) : 8'h00);
         send(speech_cmd_pkg::OP_SAI_CHANNEL);
         send(b);
         settle();
         chk({left_channel_select, left_side_enable, right_channel_select, right_side_enable},
             {b[6:4], b[2:0]}, "routing fields");
         chk(right_side_active, b[0] && !(b[4] && b[6:5] == b[2:1]), "right active");
      end
      @(posedge pclk);
      playing_n_in <= 4'hD;
      send(speech_cmd_pkg::OP_SAI_CHANNEL);
      send(8'h30);
      settle();
      chk({left_side_enable, right_side_enable}, 0, "busy refusal");
      chk({left_channel_select, right_channel_select}, 0, "refusal discarded");
      @(posedge pclk);
      playing_n_in <= 4'hF;
      send(speech_cmd_pkg::OP_SAI_CHANNEL);
      send(8'h53);
      @(posedge pclk);
      frame_clock_fast <= 1'b1;
      @(posedge pclk);
      frame_clock_fast <= 1'b0;
      settle();
      chk({left_channel_select, left_side_enable, right_channel_select, right_side_enable},
          0, "fast frame reset");
      end_of_test();
   end
endmodule // tb_speech_cmd_phrase_fault_sai
